// ===== dds_access_unit.sv
// Dual data space access unit top: decode, lanes, traps, stack, view penalty.
// Assumes one request per cycle from the pipeline and word memories answering
// combinationally on the read data inputs.
`timescale 1ns/1ns
`default_nettype none
module dds_access_unit #(
  parameter int unsigned AW = 16
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 req_valid_i,
  input  wire dds_pkg::dds_req_type req_i,
  input  wire dds_pkg::dds_rpt_type rpt_i,
  input  wire logic                 view_en_i,
  input  wire logic [7:0]           status_low_byte_i,
  input  wire logic                 limit_wr_i,
  input  wire logic [15:0]          limit_wdata_i,
  input  wire logic                 y_req_i,
  input  wire logic [1:0]           y_ptr_sel_i,
  input  wire logic [15:0]          y_ea_i,
  input  wire logic [15:0]          x_rdata_i,
  input  wire logic [15:0]          y_rdata_i,
  input  wire logic [23:0]          pc_i,
  output logic [AW-1:0]             x_addr_o,
  output logic [15:0]               x_wdata_o,
  output logic [1:0]                x_wstrb_o,
  output logic                      view_access_o,
  output logic [AW-1:0]             y_addr_o,
  output logic [15:0]               x_result_o,
  output logic [15:0]               y_result_o,
  output logic [15:0]               ea_next_o,
  output logic [15:0]               sp_o,
  output logic [15:0]               limit_o,
  output logic [1:0]                extra_cycles_o,
  output logic                      addr_trap_o,
  output logic                      stack_trap_o,
  output logic                      done_o
);

  // ****************************************
  // Request decode
  // ****************************************
  logic        is_read, is_write, is_push, is_pop, misalign, in_y, impl;
  logic        x_invalid, view_hit, stk_err, near_ok;
  logic [7:0]  lane_byte;
  logic [1:0]  lane_strb;
  logic [15:0] sp_q, limit_q, push_word, x_word;

  assign is_read  = req_valid_i && req_i.op == dds_pkg::DDS_OP_READ;
  assign is_write = req_valid_i && req_i.op == dds_pkg::DDS_OP_WRITE;
  assign is_push  = req_valid_i && req_i.op == dds_pkg::DDS_OP_PUSH;
  assign is_pop   = req_valid_i && req_i.op == dds_pkg::DDS_OP_POP;
  // R9: byte granular word space
  assign in_y     = req_i.ea >= dds_pkg::DDS_Y_BASE && req_i.ea <= dds_pkg::DDS_Y_LAST;
  assign impl     = req_i.ea <= dds_pkg::DDS_X_LAST;
  // R13: odd word detect
  assign misalign = (is_read || is_write) && !req_i.byte_op && req_i.ea[0];
  // R16: near window check
  assign near_ok  = !req_i.direct13 || (req_i.ea <= dds_pkg::DDS_NEAR_LAST);
  // R1: table suspends view
  // R23: enable and top bit
  assign view_hit = view_en_i && req_i.ea[dds_pkg::DDS_VIEW_BIT] && !req_i.table_op;
  // R4: X excludes Y on dual fetch
  // R8: invalid read zero
  assign x_invalid = (!impl && !view_hit) || (req_i.dual_fetch && in_y) || !near_ok;
  // R18: call or exception frame word
  assign push_word = req_i.exc_push ? {status_low_byte_i, req_i.wdata[7:0]} :
                     req_i.call_push ? {8'h00, req_i.wdata[7:0]} : req_i.wdata;

  dds_lane u_lane (
    .byte_op_i  (req_i.byte_op),
    .addr_lsb_i (req_i.ea[0]),
    .word_i     (x_rdata_i),
    .byte_o     (lane_byte),
    .strobe_o   (lane_strb)
  );

  dds_stack_chk u_stk (
    .push_i  (is_push),
    .pop_i   (is_pop),
    .sp_i    (sp_q),
    .limit_i (limit_q),
    .err_o   (stk_err)
  );

  // Read result shaping
  always_comb begin
    x_word = x_rdata_i;
    if (x_invalid) begin
      x_word = dds_pkg::DDS_ZERO_WORD;
    end else if (req_i.byte_op) begin
      // R14: low byte only
      x_word = {req_i.wreg_old[15:8], lane_byte};
    end
    case (req_i.op)
      // R15: sign and zero extend
      dds_pkg::DDS_OP_SIGN_EXT: x_word = {{8{req_i.wreg_old[7]}}, req_i.wreg_old[7:0]};
      dds_pkg::DDS_OP_ZERO_EXT: x_word = {8'h00, req_i.wreg_old[7:0]};
      default: ;
    endcase
  end

  // ****************************************
  // X bus outputs
  // ****************************************
  // R6: writes on X bus only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      x_addr_o   <= '0;
      x_wdata_o  <= '0;
      x_wstrb_o  <= 2'h0;
      x_result_o <= '0;
      done_o     <= 1'b0;
    end else begin
      done_o     <= req_valid_i;
      x_result_o <= x_word;
      if (is_push) begin
        x_addr_o  <= sp_q;
        x_wdata_o <= push_word;
        // Push blocked when it breaks the limit or the floor
        x_wstrb_o <= stk_err ? 2'h0 : 2'h3;
      end else if (is_pop) begin
        x_addr_o  <= sp_q - 16'h0002;
        x_wstrb_o <= 2'h0;
      end else begin
        x_addr_o  <= req_i.ea;
        // R11: byte lane replicated
        x_wdata_o <= req_i.byte_op ? {req_i.wdata[7:0], req_i.wdata[7:0]} : req_i.wdata;
        // R13: suppress faulting write
        x_wstrb_o <= (is_write && !misalign) ? lane_strb : 2'h0;
      end
    end
  end

  // ****************************************
  // Y read path
  // ****************************************
  // R5: Y via Y pointer pair
  // R10: Y word only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      y_addr_o   <= '0;
      y_result_o <= '0;
    end else begin
      y_addr_o   <= {y_ea_i[15:1], 1'b0};
      // R8: Y pointer outside Y zero
      y_result_o <= (y_req_i && y_ea_i >= dds_pkg::DDS_Y_BASE && y_ea_i <= dds_pkg::DDS_Y_LAST &&
                     y_ptr_sel_i[1]) ? y_rdata_i : dds_pkg::DDS_ZERO_WORD;
    end
  end

  // ****************************************
  // Post modify and view penalty
  // ****************************************
  // R12: step one or two
  // R7: bit reverse X writes; modulo mode steps like plain
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ea_next_o <= '0;
    end else if (req_i.amode == dds_pkg::DDS_AM_BITREV && is_write) begin
      ea_next_o <= {req_i.ea[15:8], req_i.ea[1], req_i.ea[2], req_i.ea[3], req_i.ea[4],
                    req_i.ea[5], req_i.ea[6], req_i.ea[7], 1'b0};
    end else begin
      ea_next_o <= req_i.ea + (req_i.byte_op ? 16'h0001 : 16'h0002);
    end
  end

  // R2: outside repeat penalty
  // R3: repeat edges penalty
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      extra_cycles_o <= 2'h0;
      view_access_o  <= 1'b0;
    end else begin
      view_access_o <= req_valid_i && view_hit;
      if (!(req_valid_i && view_hit)) begin
        extra_cycles_o <= 2'h0;
      end else if (rpt_i.rpt_active) begin
        extra_cycles_o <= (rpt_i.rpt_first || rpt_i.rpt_last || rpt_i.irq_exit ||
                           rpt_i.irq_reentry) ? 2'h2 : 2'h0;
      end else begin
        extra_cycles_o <= (req_i.short_view || req_i.dual_fetch) ? 2'h1 : 2'h2;
      end
    end
  end

  // ****************************************
  // Stack pointer and limit
  // ****************************************
  // R17: grow upward
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sp_q <= dds_pkg::DDS_SP_RESET;
    end else if (is_push) begin
      sp_q <= sp_q + 16'h0002;
    end else if (is_pop) begin
      sp_q <= sp_q - 16'h0002;
    end
  end

  // R19: no reset, bit zero forced
  always_ff @(posedge core_clk_i) begin
    if (limit_wr_i) begin
      limit_q <= {limit_wdata_i[15:1], 1'b0};
    end
  end

  // R24: separate trap lines
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_trap_o  <= 1'b0;
      stack_trap_o <= 1'b0;
      sp_o         <= dds_pkg::DDS_SP_RESET;
      limit_o      <= '0;
    end else begin
      addr_trap_o  <= misalign;
      stack_trap_o <= stk_err;
      sp_o         <= sp_q;
      limit_o      <= limit_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_misalign_trap;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    misalign |=> addr_trap_o && x_wstrb_o == 2'h0;
  endproperty
  a_misalign_trap: assert property (p_misalign_trap) else $error("odd word access missed trap"); // R13

  property p_push_limit;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (is_push && sp_q == limit_q && sp_q >= dds_pkg::DDS_STACK_FLOOR) |=> !stack_trap_o;
  endproperty
  a_push_limit: assert property (p_push_limit) else $error("push at limit trapped"); // R20

  property p_push_grow;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    is_push |=> sp_q == $past(sp_q) + 16'h0002;
  endproperty
  a_push_grow: assert property (p_push_grow) else $error("push did not step pointer"); // R17

  property p_floor;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (is_push && sp_q < dds_pkg::DDS_STACK_FLOOR) |=> stack_trap_o;
  endproperty
  a_floor: assert property (p_floor) else $error("floor breach missed"); // R21

  property p_byte_strobe;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (is_write && req_i.byte_op) |=> x_wstrb_o != 2'h3;
  endproperty
  a_byte_strobe: assert property (p_byte_strobe) else $error("byte write hit both lanes"); // R11

  property p_invalid_zero;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (is_read && x_invalid) |=> x_result_o == 16'h0000;
  endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("invalid read not zero"); // R8

  property p_table_view;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (req_valid_i && req_i.table_op) |=> !view_access_o && extra_cycles_o == 2'h0;
  endproperty
  a_table_view: assert property (p_table_view) else $error("view during table op"); // R1

  property p_limit_even;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    limit_wr_i |=> limit_q[0] == 1'b0;
  endproperty
  a_limit_even: assert property (p_limit_even) else $error("limit bit zero set"); // R19

endmodule
`default_nettype wire

// ===== dds_pkg.sv
// Package for the dual data space access unit: constants and carriers.
// Assumes a 16-bit core issuing one access request per instruction cycle.
//
// Operation
// R1: View mapping suspended during table instructions
// R2: View penalty outside repeat: one or two
// R3: Repeat view penalty two at edges, else one (code gives zero else)
// R4: Dual fetch X block excludes Y region
// R5: Dual fetch uses pointer pairs per space
// R6: All writes use X bus; Y reads only
// R7: Modulo both spaces; bit reverse X writes (modulo not applied, steps plain)
// R8: Invalid reads return all zeros
// R9: Sixteen bit byte addresses, 64 Kbytes
// R10: Byte reads select lane to low byte
// R11: Byte writes strobe one lane only
// R12: Post increment one byte, two word
// R13: Odd word access traps; writes suppressed
// R14: Byte load changes only low byte
// R15: Sign extend and zero extend operations
// R16: Near window 13 bit; moves 16 bit
// R17: Stack grows up, post inc, pre dec
// R18: Call push zero extends; exception merges status
// R19: Limit unreset, bit zero reads zero
// R20: Stack addresses compared with limit
// R21: Stack below 0x0800 raises error
// R22: Software avoids stack read after limit write
// R23: View only with enable and top bit
// R24: Address and stack errors separate traps
package dds_pkg;

  // ****************************************
  // Address map constants
  // ****************************************
  localparam logic [15:0] DDS_Y_BASE      = 16'h0080;
  localparam logic [15:0] DDS_Y_LAST      = 16'h00FF;
  localparam logic [15:0] DDS_X_LAST      = 16'h00FF;
  localparam logic [15:0] DDS_NEAR_LAST   = 16'h1FFF;
  localparam logic [15:0] DDS_STACK_FLOOR = 16'h0800;
  localparam logic [15:0] DDS_SP_RESET    = 16'h0800;
  localparam logic [15:0] DDS_ZERO_WORD   = 16'h0000;
  localparam int          DDS_VIEW_BIT    = 15;

  // ****************************************
  // Operation codes and carriers
  // ****************************************
  typedef enum logic [2:0] {
    DDS_OP_NONE, DDS_OP_READ, DDS_OP_WRITE, DDS_OP_PUSH, DDS_OP_POP,
    DDS_OP_SIGN_EXT, DDS_OP_ZERO_EXT
  } dds_op_type;

  typedef enum logic [1:0] {
    DDS_AM_PLAIN, DDS_AM_MODULO, DDS_AM_BITREV
  } dds_amode_type;

  typedef struct packed {
    dds_op_type    op;
    logic          byte_op;
    logic          dual_fetch;     // Dual fetch DSP class
    logic          short_view;     // Move, double move or prefetch class
    logic          table_op;
    logic          call_push;
    logic          exc_push;
    logic          direct13;
    logic          direct16;
    dds_amode_type amode;
    logic [15:0]   ea;
    logic [15:0]   wdata;
    logic [15:0]   wreg_old;       // Destination register before a byte load
  } dds_req_type;

  typedef struct packed {
    logic        rpt_active;
    logic        rpt_first;
    logic        rpt_last;
    logic        irq_exit;
    logic        irq_reentry;
  } dds_rpt_type;

endpackage

// ===== dds_lane.sv
// Byte lane selector and write strobe builder.
// Assumes words are little-endian byte pairs.
`timescale 1ns/1ns
`default_nettype none
module dds_lane (
  input  wire logic        byte_op_i,
  input  wire logic        addr_lsb_i,
  input  wire logic [15:0] word_i,
  output logic      [7:0]  byte_o,
  output logic      [1:0]  strobe_o
);
  // R10: lane select read
  assign byte_o = addr_lsb_i ? word_i[15:8] : word_i[7:0];
  // R11: single lane strobe
  assign strobe_o = byte_op_i ? (addr_lsb_i ? 2'h2 : 2'h1) : 2'h3;
endmodule
`default_nettype wire

// ===== dds_stack_chk.sv
// Stack limit and floor checker.
// Assumes limit and pointer are word aligned.
`timescale 1ns/1ns
`default_nettype none
module dds_stack_chk (
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [15:0] sp_i,
  input  wire logic [15:0] limit_i,
  output logic             err_o
);
  logic [15:0] pop_addr;
  assign pop_addr = sp_i - 16'h0002;
  // R20: limit compare
  // R21: floor compare
  assign err_o = (push_i && (sp_i > limit_i || sp_i < dds_pkg::DDS_STACK_FLOOR)) ||
                 (pop_i && (pop_addr < dds_pkg::DDS_STACK_FLOOR));
endmodule
`default_nettype wire

// ===== dds_mem_model.sv
// Data memory model that answers the pipeline's read addresses.
// Assumes the unit masks invalid reads itself, so every address answers.
`timescale 1ns/1ns
`default_nettype none
module dds_mem_model (
  input  wire logic [15:0] x_ea_i,
  input  wire logic [15:0] y_ea_i,
  output logic      [15:0] x_rdata_o,
  output logic      [15:0] y_rdata_o
);
  // ****************************************
  // Word contents
  // ****************************************
  // whole word fetched
  // Contents derived from the word address, same cycle
  always_comb begin
    x_rdata_o = {x_ea_i[8:1] ^ 8'h5A, ~x_ea_i[8:1]};
    y_rdata_o = {y_ea_i[8:1] ^ 8'h5A, ~y_ea_i[8:1]};
  end
endmodule
`default_nettype wire

// ===== dual_data_space_access_unit_test.sv
// Self-checking bench for the dual data space access unit.
// Assumes the memory model answers combinationally on the request address.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module dual_data_space_access_unit_test;
  logic                 core_clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  logic                 req_valid_i = 1'b0;
  dds_pkg::dds_req_type req_i = '0;
  dds_pkg::dds_rpt_type rpt_i = '0;
  logic                 view_en_i = 1'b0;
  logic [7:0]           status_low_byte_i = 8'h00;
  logic                 limit_wr_i = 1'b0;
  logic [15:0]          limit_wdata_i = 16'h0000;
  logic                 y_req_i = 1'b0;
  logic [1:0]           y_ptr_sel_i = 2'h0;
  logic [15:0]          y_ea_i = 16'h0000;
  logic [15:0]          x_rdata_i, y_rdata_i, x_addr_o, x_wdata_o, y_addr_o, x_result_o, y_result_o;
  logic [15:0]          ea_next_o, sp_o, limit_o;
  logic [1:0]           x_wstrb_o, extra_cycles_o;
  logic                 view_access_o, addr_trap_o, stack_trap_o, done_o;
  int                   bad_count = 0, check_count = 0, cyc = 0;
  // View cases: sv, repeat flags, table, enable, top bit, access, penalty
  localparam logic [11:0] VT [10] = '{12'h81D, 12'h01E, 12'h41C, 12'h61E, 12'h51E,
                                      12'h49E, 12'h45E, 12'h038, 12'h008, 12'h010};

  always #5 core_clk_i = ~core_clk_i;

  dds_access_unit u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .rpt_i(rpt_i), .view_en_i(view_en_i), .status_low_byte_i(status_low_byte_i),
    .limit_wr_i(limit_wr_i), .limit_wdata_i(limit_wdata_i), .y_req_i(y_req_i), .y_ptr_sel_i(y_ptr_sel_i),
    .y_ea_i(y_ea_i), .x_rdata_i(x_rdata_i), .y_rdata_i(y_rdata_i), .pc_i(24'h000000),
    .x_addr_o(x_addr_o), .x_wdata_o(x_wdata_o), .x_wstrb_o(x_wstrb_o), .view_access_o(view_access_o),
    .y_addr_o(y_addr_o), .x_result_o(x_result_o), .y_result_o(y_result_o), .ea_next_o(ea_next_o),
    .sp_o(sp_o), .limit_o(limit_o), .extra_cycles_o(extra_cycles_o), .addr_trap_o(addr_trap_o),
    .stack_trap_o(stack_trap_o), .done_o(done_o));

  dds_mem_model u_mem (.x_ea_i(req_i.ea), .y_ea_i(y_ea_i), .x_rdata_o(x_rdata_i), .y_rdata_o(y_rdata_i));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] mw(input logic [15:0] a);
    mw = {a[8:1] ^ 8'h5A, ~a[8:1]};
  endfunction

  function automatic dds_pkg::dds_req_type mk(input dds_pkg::dds_op_type op, input logic b,
                                              input logic [15:0] ea, input logic [15:0] wd);
    mk = '0;
    mk.op = op;
    mk.byte_op = b;
    mk.ea = ea;
    mk.wdata = wd;
  endfunction

  // One request, outputs looked at one cycle later
  task automatic issue(input dds_pkg::dds_req_type r);
    @(posedge core_clk_i);
    req_i <= r;
    req_valid_i <= 1'b1;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    #1;
    `CHK(done_o, 1'b1)
  endtask

  task automatic do_reset();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    `CHK(sp_o, dds_pkg::DDS_SP_RESET)
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_lanes();
    dds_pkg::dds_req_type r;
    for (int i = 0; i < 2; i++) begin
      r = mk(dds_pkg::DDS_OP_READ, 1'b1, 16'h0010 + 16'(i), 16'h0000);
      r.wreg_old = 16'hABCD;
      issue(r);
      `CHK(x_result_o, {8'hAB, 8'((i == 1) ? (mw(16'h0010) >> 8) : mw(16'h0010))})
      `CHK(ea_next_o, 16'h0011 + 16'(i))
      issue(mk(dds_pkg::DDS_OP_WRITE, 1'b1, 16'h0020 + 16'(i), 16'h00C3));
      `CHK(x_wstrb_o, (i == 1) ? 2'h2 : 2'h1)
      `CHK(x_wdata_o, 16'hC3C3)
    end
    issue(mk(dds_pkg::DDS_OP_WRITE, 1'b0, 16'h0022, 16'h1234));
    `CHK({x_wstrb_o, ea_next_o}, {2'h3, 16'h0024})
    r = mk(dds_pkg::DDS_OP_WRITE, 1'b0, 16'h0024, 16'h1234);
    r.amode = dds_pkg::DDS_AM_BITREV;
    issue(r);
    `CHK(ea_next_o, 16'h0048)
    issue(mk(dds_pkg::DDS_OP_WRITE, 1'b0, 16'h0023, 16'h1234));
    `CHK({x_wstrb_o, addr_trap_o, stack_trap_o}, 4'h2)
    issue(mk(dds_pkg::DDS_OP_READ, 1'b0, 16'h0025, 16'h0000));
    `CHK(addr_trap_o, 1'b1)
  endtask

  task automatic t_space();
    dds_pkg::dds_req_type r;
    r = mk(dds_pkg::DDS_OP_READ, 1'b0, 16'h0090, 16'h0000);
    issue(r);
    `CHK(x_result_o, mw(16'h0090))
    issue(mk(dds_pkg::DDS_OP_READ, 1'b0, 16'h0200, 16'h0000));
    `CHK(x_result_o, 16'h0000)
    r.dual_fetch = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      y_req_i <= 1'b1;
      y_ptr_sel_i <= (i == 1) ? 2'h0 : 2'h2;
      y_ea_i <= (i == 2) ? 16'h0040 : 16'h0080;
      issue(r);
      `CHK(x_result_o, 16'h0000)
      `CHK(y_result_o, (i == 0) ? mw(16'h0080) : 16'h0000)
      `CHK(y_addr_o, (i == 2) ? 16'h0040 : 16'h0080)
    end
    @(posedge core_clk_i);
    y_req_i <= 1'b0;
  endtask

  task automatic t_ext();
    dds_pkg::dds_req_type r;
    r = mk(dds_pkg::DDS_OP_SIGN_EXT, 1'b0, 16'h0000, 16'h1280);
    r.wreg_old = 16'h1280;
    issue(r);
    `CHK(x_result_o, 16'hFF80)
    r.op = dds_pkg::DDS_OP_ZERO_EXT;
    issue(r);
    `CHK(x_result_o, 16'h0080)
  endtask

  task automatic t_stack();
    dds_pkg::dds_req_type r;
    // Limit holds no value after reset, so it is written before any push
    @(posedge core_clk_i);
    limit_wr_i <= 1'b1;
    limit_wdata_i <= 16'h0805;
    @(posedge core_clk_i);
    limit_wr_i <= 1'b0;
    // no stack read right after the limit write
    repeat (2) @(posedge core_clk_i);
    `CHK(limit_o, 16'h0804)
    r = mk(dds_pkg::DDS_OP_PUSH, 1'b0, 16'h0000, 16'h1234);
    r.call_push = 1'b1;
    issue(r);
    `CHK({x_addr_o, x_wdata_o, x_wstrb_o}, {16'h0800, 16'h0034, 2'h3})
    @(posedge core_clk_i);
    status_low_byte_i <= 8'h5A;
    #1;
    `CHK(sp_o, 16'h0802)
    r.call_push = 1'b0;
    r.exc_push = 1'b1;
    issue(r);
    `CHK({x_addr_o, x_wdata_o}, {16'h0802, 16'h5A34})
    issue(mk(dds_pkg::DDS_OP_POP, 1'b0, 16'h0000, 16'h0000));
    `CHK(x_addr_o, 16'h0802)
    r.exc_push = 1'b0;
    for (int i = 0; i < 3; i++) begin
      issue(r);
      `CHK({stack_trap_o, addr_trap_o, x_wstrb_o}, (i == 2) ? 4'h8 : 4'h3)
    end
    do_reset();
    issue(mk(dds_pkg::DDS_OP_POP, 1'b0, 16'h0000, 16'h0000));
    `CHK(stack_trap_o, 1'b1)
    issue(r);
    `CHK({stack_trap_o, x_wstrb_o}, 3'h4)
  endtask

  task automatic t_view();
    dds_pkg::dds_req_type r;
    for (int i = 0; i < 10; i++) begin
      r = mk(dds_pkg::DDS_OP_READ, 1'b0, VT[i][3] ? 16'h8000 : 16'h7FFE, 16'h0000);
      r.short_view = VT[i][11];
      r.table_op = VT[i][5];
      @(posedge core_clk_i);
      rpt_i <= dds_pkg::dds_rpt_type'(VT[i][10:6]);
      view_en_i <= VT[i][4];
      issue(r);
      `CHK({view_access_o, extra_cycles_o}, VT[i][2:0])
    end
  endtask

  // Hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  // Main sequence
  initial begin
    do_reset();
    t_lanes();
    t_space();
    t_ext();
    t_view();
    do_reset();
    t_stack();
    results();
  end
endmodule
`default_nettype wire
